/* rtl/pbseq_top.sv */
/*
  Push-button power sequencer: detects button use at supply-valid,
  qualifies 20 ms presses, drives master enable, warning and enables.
  Assumes rst marks input power recycling and supply_ok is a level
  from an analog comparator (asynchronous, synchronised here).
*/
// Contract
// - Sample the button only once the internal supply is valid, decide use.
// - Button tied low: power on after 20 ms of continuous low.
// - Button high at detection: stay off until first valid press.
// - When on, each converter follows its own enable, gated by master.
// - A 20 ms power-on press asserts master enable.
// - While on, a 20 ms press drives the warning output low.
// - Master enable drops 1024 ms after the warning goes low.
// - Master enable low forces every converter off.
// - After shutdown stay off until a new press or power recycle.
`timescale 1ns/1ps
module pbseq_top #(
  parameter int unsigned HOLD_CYCLES = pbseq_pkg::HOLD_CYC,
  parameter int unsigned WARN_CYCLES = pbseq_pkg::WARN_CYC,
  parameter int unsigned NUM_CONV = pbseq_pkg::NCONV
) (
  // Clock and reset
  input wire logic clock,
  input wire logic rst,
  // Analog and pin inputs
  input wire logic supply_ok,
  input wire logic button_input,
  input wire logic [NUM_CONV-1:0] converter_enable_inputs,
  // Outputs
  output logic [NUM_CONV-1:0] converter_enable_q,
  output logic master_enable_q,
  output logic int_n_q
);
  import pbseq_pkg::*;

  initial begin
    if (HOLD_CYCLES < 1 || WARN_CYCLES < 1 || HOLD_CYCLES >= (1 << CNT_W)
        || WARN_CYCLES >= (1 << CNT_W) || NUM_CONV < 1) begin
      $error("pbseq_top: unsupported parameter values");
    end
  end

  localparam logic [CNT_W-1:0] HOLD_LAST = CNT_W'(HOLD_CYCLES - 1);
  localparam logic [CNT_W-1:0] WARN_LAST = CNT_W'(WARN_CYCLES - 1);
  localparam logic [CNT_W-1:0] CNT_ZERO = '0;

  // ************************************************************
  // Input synchronisers
  // ************************************************************
  logic btn_lvl;
  logic btn_fall;
  logic sup_lvl;

  pbseq_sync u_btn (
    .clock(clock),
    .rst(rst),
    .async_in(button_input),
    .level_q(btn_lvl),
    .fall_q(btn_fall)
  );

  logic sup_meta_q;
  logic sup_meta_d;
  logic sup_q;
  logic sup_d;
  assign sup_lvl = sup_q;

  always_comb begin
    sup_meta_d = supply_ok;
    sup_d = sup_meta_q;
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      sup_meta_q <= 1'b0;
      sup_q <= 1'b0;
    end else begin
      sup_meta_q <= sup_meta_d;
      sup_q <= sup_d;
    end
  end

  // ************************************************************
  // Sequencer
  // ************************************************************
  pbseq_state_t state_q;
  pbseq_state_t state_d;
  logic [CNT_W-1:0] cnt_q;
  logic [CNT_W-1:0] cnt_d;
  logic timing_q;
  logic timing_d;
  pbseq_status_t stat_q;
  pbseq_status_t stat_d;
  logic [NUM_CONV-1:0] conv_d;

  // Hold qualifier: counts while a press stays low, aborts on release.
  // A tied-low button has no falling edge, so DETECT starts timing itself.
  always_comb begin
    state_d = state_q;
    cnt_d = cnt_q;
    timing_d = timing_q;
    stat_d = stat_q;
    unique case (state_q)
      PBSEQ_WAIT_SUPPLY: begin
        if (sup_lvl) begin
          state_d = PBSEQ_DETECT;
        end
      end
      PBSEQ_DETECT: begin
        if (btn_lvl) begin
          state_d = PBSEQ_OFF;
          timing_d = 1'b0;
        end else begin
          state_d = PBSEQ_OFF;
          timing_d = 1'b1;
          cnt_d = CNT_ZERO;
        end
      end
      PBSEQ_OFF, PBSEQ_ON: begin
        if (timing_q) begin
          if (btn_lvl) begin
            timing_d = 1'b0;
          end else if (cnt_q == HOLD_LAST) begin
            timing_d = 1'b0;
            cnt_d = CNT_ZERO;
            if (state_q == PBSEQ_OFF) begin
              state_d = PBSEQ_ON;
              stat_d.master_enable = 1'b1;
              stat_d.warn_n = 1'b1;
            end else begin
              state_d = PBSEQ_WARN;
              stat_d.warn_n = 1'b0;
            end
          end else begin
            cnt_d = cnt_q + 1'b1;
          end
        end else if (btn_fall) begin
          timing_d = 1'b1;
          cnt_d = CNT_ZERO;
        end
      end
      PBSEQ_WARN: begin
        if (cnt_q == WARN_LAST) begin
          state_d = PBSEQ_OFF;
          stat_d.master_enable = 1'b0;
          cnt_d = CNT_ZERO;
        end else begin
          cnt_d = cnt_q + 1'b1;
        end
      end
      default: begin
        state_d = PBSEQ_WAIT_SUPPLY;
      end
    endcase
    // Enables gated by the master; host is trusted to finish in time
    conv_d = stat_d.master_enable ? converter_enable_inputs : '0;
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      state_q <= PBSEQ_WAIT_SUPPLY;
      cnt_q <= CNT_ZERO;
      timing_q <= 1'b0;
      stat_q <= '{master_enable: 1'b0, warn_n: 1'b1};
      converter_enable_q <= '0;
    end else begin
      state_q <= state_d;
      cnt_q <= cnt_d;
      timing_q <= timing_d;
      stat_q <= stat_d;
      converter_enable_q <= conv_d;
    end
  end

  always_comb begin
    master_enable_q = stat_q.master_enable;
    int_n_q = stat_q.warn_n;
  end

  // ************************************************************
  // Checks
  // ************************************************************
  conv_gated_a: assert property (@(posedge clock) disable iff (rst)
    !master_enable_q |-> converter_enable_q == '0)
    else $error("converter enabled while master off");

  conv_follow_a: assert property (@(posedge clock) disable iff (rst)
    master_enable_q && $past(master_enable_q) |->
      converter_enable_q == $past(converter_enable_inputs))
    else $error("converter enable does not follow its input");

  no_early_on_a: assert property (@(posedge clock) disable iff (rst)
    state_q == PBSEQ_WAIT_SUPPLY || state_q == PBSEQ_DETECT |-> !master_enable_q)
    else $error("powered on before detection");

  on_after_hold_a: assert property (@(posedge clock) disable iff (rst)
    $rose(master_enable_q) |-> $past(timing_q) && $past(cnt_q) == HOLD_LAST)
    else $error("master enable without full hold");

  warn_after_hold_a: assert property (@(posedge clock) disable iff (rst)
    $fell(int_n_q) |-> $past(state_q) == PBSEQ_ON && $past(cnt_q) == HOLD_LAST)
    else $error("warning without full hold");

  off_after_warn_a: assert property (@(posedge clock) disable iff (rst)
    $fell(master_enable_q) |-> !int_n_q && $past(cnt_q) == WARN_LAST)
    else $error("master dropped at wrong time");

  release_abort_a: assert property (@(posedge clock) disable iff (rst)
    timing_q && btn_lvl |=> !timing_q && $stable(master_enable_q))
    else $error("released press not discarded");

  warn_release_a: assert property (@(posedge clock) disable iff (rst)
    $rose(int_n_q) |-> $rose(master_enable_q))
    else $error("warning released without power on");

  stay_off_a: assert property (@(posedge clock) disable iff (rst)
    state_q == PBSEQ_OFF && !timing_q && !btn_fall |=> !master_enable_q && !timing_q)
    else $error("left off state without new press");

  detect_sup_a: assert property (@(posedge clock) disable iff (rst)
    state_q == PBSEQ_DETECT |-> $past(sup_lvl))
    else $error("detection before supply valid");
endmodule

/* rtl/pbseq_pkg.sv */
/*
  Constants and carrier types for the push-button power sequencer.
  Assumes a 200 MHz clock; times are turned into cycle counts here.
*/
package pbseq_pkg;
  // ************************************************************
  // Timing
  // ************************************************************
  localparam int unsigned CLOCK_MHZ = 200;
  localparam int unsigned HOLD_MS = 20;
  localparam int unsigned WARN_MS = 1024;
  localparam int unsigned CYC_PER_MS = CLOCK_MHZ * 1000;
  localparam int unsigned HOLD_CYC = HOLD_MS * CYC_PER_MS;
  localparam int unsigned WARN_CYC = WARN_MS * CYC_PER_MS;
  localparam int unsigned CNT_W = 28;
  localparam int unsigned NCONV = 3;

  // ************************************************************
  // Types
  // ************************************************************
  typedef enum logic [2:0] {
    PBSEQ_WAIT_SUPPLY = 3'b000,
    PBSEQ_DETECT = 3'b001,
    PBSEQ_OFF = 3'b011,
    PBSEQ_ON = 3'b010,
    PBSEQ_WARN = 3'b110
  } pbseq_state_t;

  typedef struct packed {
    logic master_enable;
    logic warn_n;
  } pbseq_status_t;
endpackage

/* rtl/pbseq_sync.sv */
/*
  Two-flop synchroniser with falling-edge detect on the settled copy.
  Assumes the input is asynchronous to clock.
*/
`timescale 1ns/1ps
module pbseq_sync (
  // Clock and reset
  input wire logic clock,
  input wire logic rst,
  // Pin side
  input wire logic async_in,
  // Synchronised side
  output logic level_q,
  output logic fall_q
);
  logic meta_q;
  logic meta_d;
  logic level_d;
  logic prev_q;
  logic prev_d;
  logic fall_d;

  always_comb begin
    meta_d = async_in;
    level_d = meta_q;
    prev_d = level_q;
    fall_d = prev_q & ~level_q;
  end

  // Reset high: an idle released button
  always_ff @(posedge clock) begin
    if (rst) begin
      meta_q <= 1'b1;
      level_q <= 1'b1;
      prev_q <= 1'b1;
      fall_q <= 1'b0;
    end else begin
      meta_q <= meta_d;
      level_q <= level_d;
      prev_q <= prev_d;
      fall_q <= fall_d;
    end
  end
endmodule

/* testbench/pbseq_partner.sv */
/*
  Button and host stand-in for the sequencer bench.
  Assumes the bench clock; pin changes land on the falling edge.
*/
`timescale 1ns/1ps
module pbseq_partner (
  // Clock
  input wire logic clock,
  // Pins
  input wire logic int_n,
  output logic button
);
  int warn_seen;
  initial begin
    button = 1'b1;
    warn_seen = 0;
  end
  // ************************************************************
  // Button
  // ************************************************************
  // High to low, held n cycles, then released
  task automatic press(input int n);
    @(negedge clock);
    button = 1'b0;
    repeat (n) @(negedge clock);
    button = 1'b1;
  endtask
  task automatic set_level(input logic v);
    @(negedge clock);
    button = v;
  endtask
  // ************************************************************
  // Host
  // ************************************************************
  // Housekeeping is taken as instant, well inside the delay
  always @(negedge int_n) warn_seen++;
endmodule

/* testbench/tb_pbseq_top.sv */
/*
  Self-checking bench for the push-button power sequencer.
  Assumes short hold and warning counts set through parameters.
*/
`timescale 1ns/1ps
module tb_pbseq_top;
  import pbseq_pkg::*;
  localparam int HOLD = 20;
  localparam int WARN = 100;
  logic clock = 1'b0;
  logic rst = 1'b1;
  logic supply_ok = 1'b0;
  logic [NCONV-1:0] conv_in = 3'b111;
  logic [NCONV-1:0] conv_q;
  logic master, int_n, button;
  int n_fail = 0;
  int checks_done = 0;
  int m, m2;
  // ************************************************************
  // Harness
  // ************************************************************
  initial forever #2.5 clock = ~clock;
  pbseq_top #(.HOLD_CYCLES(HOLD), .WARN_CYCLES(WARN)) uut (
    .clock(clock), .rst(rst), .supply_ok(supply_ok), .button_input(button),
    .converter_enable_inputs(conv_in), .converter_enable_q(conv_q),
    .master_enable_q(master), .int_n_q(int_n));
  pbseq_partner partner (.clock(clock), .int_n(int_n), .button(button));
  task automatic check(input string what, input logic [2:0] seen, input logic [2:0] exp);
    checks_done++;
    if (seen !== exp) begin
      $display("wrong value %s expected %h seen %h", what, exp, seen);
      n_fail++;
    end
  endtask
  // Sync and edge stages add a few cycles to every press-timed count
  function automatic logic near(input int got, input int want);
    return (got >= want + 1) && (got <= want + 8);
  endfunction
  task automatic until_change(input bit sel, output int n);
    logic v0;
    v0 = sel ? int_n : master;
    n = 0;
    while ((sel ? int_n : master) === v0 && n < 400) begin
      @(negedge clock);
      n++;
    end
  endtask
  // Called at a falling edge; holds reset for five cycles
  task automatic power_cycle();
    rst = 1'b1;
    supply_ok = 1'b0;
    repeat (5) @(negedge clock);
    rst = 1'b0;
  endtask
  // ************************************************************
  // Scenarios
  // ************************************************************
  task automatic t_tied();
    partner.set_level(1'b0);
    power_cycle();
    repeat (3 * HOLD) @(negedge clock);
    check("no supply master", master, 1'b0);
    supply_ok = 1'b1;
    until_change(1'b0, m);
    check("tied on time", near(m, HOLD), 1'b1);
    partner.set_level(1'b1);
    $display("test tied done");
  endtask
  task automatic t_idle();
    power_cycle();
    supply_ok = 1'b1;
    repeat (3 * HOLD) @(negedge clock);
    check("idle master", master, 1'b0);
    partner.press(HOLD / 2);
    repeat (2 * HOLD) @(negedge clock);
    check("short press", master, 1'b0);
    $display("test idle done");
  endtask
  task automatic t_on();
    fork
      partner.press(HOLD + 10);
      until_change(1'b0, m);
    join
    check("on time", near(m, HOLD), 1'b1);
    check("int released", int_n, 1'b1);
    conv_in = 3'b101;
    repeat (2) @(negedge clock);
    check("enables", conv_q, 3'b101);
    conv_in = 3'b010;
    repeat (2) @(negedge clock);
    check("enables", conv_q, 3'b010);
    $display("test on done");
  endtask
  task automatic t_off();
    fork
      partner.press(HOLD + 10);
      begin
        until_change(1'b1, m);
        until_change(1'b0, m2);
      end
    join
    check("warn time", near(m, HOLD), 1'b1);
    check("off delay", m2 == WARN, 1'b1);
    check("host warned", partner.warn_seen == 1, 1'b1);
    check("forced off", conv_q, 3'b000);
    repeat (3 * HOLD) @(negedge clock);
    check("stays off", master, 1'b0);
    check("int held", int_n, 1'b0);
    $display("test off done");
  endtask
  // ************************************************************
  // Sequence and verdict
  // ************************************************************
  task automatic results();
    $display("checks %0d mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  initial begin
    #20000;
    n_fail++;
    results();
  end
  initial begin
    t_tied();
    t_idle();
    t_on();
    t_off();
    t_on();
    results();
  end
endmodule
